// [hw/mcss_consts.vh]
// Purpose: Shared constants of the catch-spin supervisor and speed-command front end
// Assumes: One 250 MHz clock, active-low asynchronous reset
// Notes:   Included by every design file of the block
`ifndef MCSS_CONSTS_VH
`define MCSS_CONSTS_VH

`define MCSS_CLK_PERIOD_NS   4
`define MCSS_MODE_SERIAL     2'h0
`define MCSS_MODE_ANALOGUE   2'h1
`define MCSS_MODE_FREQ       2'h2
`define MCSS_MODE_DUTY       2'h3
`define MCSS_ST_IDLE         3'h0
`define MCSS_ST_SYNC_WAIT    3'h1
`define MCSS_ST_ANGLE_PROBE  3'h2
`define MCSS_ST_RUN          3'h3
`define MCSS_ST_FAULT        3'h4
`define MCSS_FULL_SCALE      16'h3FFF
`define MCSS_GAIN_SHIFT      7
`define MCSS_FREQ_GATE_MS    100
`define MCSS_FREQ_GATE_CYC   (`MCSS_FREQ_GATE_MS * 1000000 / `MCSS_CLK_PERIOD_NS)
`define MCSS_ANGLE_PROBE_US  6000
`define MCSS_ANGLE_PROBE_CYC (`MCSS_ANGLE_PROBE_US * 1000 / `MCSS_CLK_PERIOD_NS)

`endif

// [hw/mcss_cmd_map.v]
// Purpose: Maps one sampled command input onto run request and signed target speed
// Assumes: Counts precomputed by software, stop count below start count
// Notes:   Outputs change only on a sample strobe
`timescale 1ns/10ps
`include "mcss_consts.vh"
module mcss_cmd_map #(
    parameter IN_W = 16
) (
    input  wire                   clk_i,
    input  wire                   nrst_i,
    input  wire                   sample_valid_i,
    input  wire [IN_W-1:0]        sample_i,
    input  wire                   dir_i,
    input  wire [IN_W-1:0]        start_threshold_count_i,
    input  wire [IN_W-1:0]        stop_threshold_count_i,
    input  wire [IN_W-1:0]        max_threshold_count_i,
    input  wire [15:0]            input_to_speed_gain_i,
    input  wire [15:0]            min_speed_code_i,
    output reg                    run_o,
    output reg  signed [15:0]     speed_o
);
    wire [IN_W-1:0]     span;
    wire [IN_W+15:0]    product;
    wire [IN_W+16:0]    scaled;
    wire [15:0]         magnitude;

    // Span above start count, scaled by gain over 128, offset by min speed code
    assign span      = (sample_i > start_threshold_count_i) ?
                       (sample_i - start_threshold_count_i) : {IN_W{1'b0}};
    assign product   = span * input_to_speed_gain_i;
    assign scaled    = {1'b0, product >> `MCSS_GAIN_SHIFT} + {{(IN_W+1){1'b0}}, min_speed_code_i};
    assign magnitude = ((sample_i >= max_threshold_count_i) ||
                        (scaled > {{(IN_W+1){1'b0}}, `MCSS_FULL_SCALE})) ?
                       `MCSS_FULL_SCALE : scaled[15:0];

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_o   <= 1'b0;
            speed_o <= 16'h0000;
        end else if (sample_valid_i) begin
            if (sample_i > start_threshold_count_i) begin
                run_o <= 1'b1;
            end else if (sample_i < stop_threshold_count_i) begin
                run_o <= 1'b0;
            end
            // Otherwise hold the present run state
            speed_o <= dir_i ? (16'h0000 - magnitude) : magnitude;
        end
    end
endmodule

// [hw/mcss_freq_meter.v]
// Purpose: Counts rising edges of the pulse command input over a fixed gate
// Assumes: Input synchronous to clk_i; 100 ms gate gives counts in units of 10 Hz
// Notes:   Count saturates at all ones
`timescale 1ns/10ps
`include "mcss_consts.vh"
module mcss_freq_meter #(
    parameter GATE_CYCLES = `MCSS_FREQ_GATE_CYC,
    parameter CNT_W       = 16
) (
    input  wire                 clk_i,
    input  wire                 nrst_i,
    input  wire                 pulse_i,
    output reg  [CNT_W-1:0]     count_o,
    output reg                  valid_o
);
    reg [31:0]      gate_cnt;
    reg [CNT_W-1:0] edge_cnt;
    reg             pulse_d;
    wire            rise;
    wire            gate_end;

    assign rise     = pulse_i & ~pulse_d;
    assign gate_end = (gate_cnt >= GATE_CYCLES - 1);

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_cnt <= 32'h00000000;
            edge_cnt <= {CNT_W{1'b0}};
            pulse_d  <= 1'b0;
            count_o  <= {CNT_W{1'b0}};
            valid_o  <= 1'b0;
        end else begin
            pulse_d <= pulse_i;
            valid_o <= gate_end;
            if (gate_end) begin
                gate_cnt <= 32'h00000000;
                count_o  <= edge_cnt;
                edge_cnt <= {CNT_W{1'b0}};
            end else begin
                gate_cnt <= gate_cnt + 32'h00000001;
                if (rise && (edge_cnt != {CNT_W{1'b1}})) begin
                    edge_cnt <= edge_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// [hw/mcss_top.v]
// Purpose: Catch-spin start supervision and speed-command selection for a PM motor drive
// Assumes: Measured speed and fault come from the estimator and protection logic
// Notes:   Speed codes are signed, full scale 16383; all outputs are registered
`timescale 1ns/10ps
`include "mcss_consts.vh"
module mcss_top #(
    parameter FREQ_GATE_CYCLES   = `MCSS_FREQ_GATE_CYC,
    parameter ANGLE_PROBE_CYCLES = `MCSS_ANGLE_PROBE_CYC
) (
    input  wire                 clk_i,
    input  wire                 nrst_i,
    input  wire [1:0]           cmd_mode_i,
    input  wire                 catch_spin_en_i,
    input  wire [31:0]          sync_wait_duration_i,
    input  wire [15:0]          direct_run_speed_threshold_i,
    input  wire [15:0]          braking_speed_threshold_i,
    input  wire [15:0]          braking_torque_limit_i,
    input  wire [15:0]          motoring_torque_limit_i,
    input  wire [15:0]          ramp_step_i,
    input  wire signed [15:0]   measured_speed_i,
    input  wire                 fault_i,
    input  wire                 fault_clear_i,
    input  wire                 serial_start_i,
    input  wire                 serial_stop_i,
    input  wire                 serial_speed_valid_i,
    input  wire signed [15:0]   serial_speed_i,
    input  wire                 adc_valid_i,
    input  wire [11:0]          adc_speed_i,
    input  wire                 pulse_command_input_i,
    input  wire                 duty_valid_i,
    input  wire [15:0]          duty_count_i,
    input  wire                 dir_i,
    input  wire [15:0]          start_threshold_count_i,
    input  wire [15:0]          stop_threshold_count_i,
    input  wire [15:0]          max_threshold_count_i,
    input  wire [15:0]          input_to_speed_gain_i,
    input  wire [15:0]          min_speed_code_i,
    output reg  [2:0]           state_o,
    output reg                  inject_enable_o,
    output reg  signed [15:0]   speed_reference_o,
    output reg  signed [15:0]   commanded_speed_o,
    output reg  [15:0]          torque_limit_o,
    output reg                  braking_o,
    output reg                  fault_o,
    output reg                  running_o
);
    reg  [2:0]          state;
    reg  [31:0]         wait_cnt;
    reg                 serial_run;
    reg  signed [15:0]  serial_speed;
    reg  [1:0]          mode_d;
    reg                 run_req;
    reg  signed [15:0]  target;
    reg  signed [15:0]  ramp;
    reg  [2:0]          next_state;
    reg  [31:0]         next_wait_cnt;
    reg  signed [15:0]  next_ramp;
    reg  signed [16:0]  ramp_up;
    reg  signed [16:0]  ramp_dn;
    reg                 is_braking;
    reg  [15:0]         motor_cap;
    wire                amap_run;
    wire signed [15:0]  amap_speed;
    wire                fmap_run;
    wire signed [15:0]  fmap_speed;
    wire                dmap_run;
    wire signed [15:0]  dmap_speed;
    wire [15:0]         freq_count;
    wire                freq_valid;
    wire [15:0]         meas_abs;
    wire                wait_done;
    wire                probe_done;

    assign meas_abs   = measured_speed_i[15] ? (16'h0000 - measured_speed_i) : measured_speed_i;
    assign wait_done  = (wait_cnt + 32'h00000001 >= sync_wait_duration_i);
    assign probe_done = (wait_cnt >= ANGLE_PROBE_CYCLES - 1);

    // Analogue command: speed voltage plus separate direction pin
    mcss_cmd_map #(
        .IN_W                    (16)
    ) u_amap (
        .clk_i                   (clk_i),
        .nrst_i                  (nrst_i),
        .sample_valid_i          (adc_valid_i),
        .sample_i                ({4'h0, adc_speed_i}),
        .dir_i                   (dir_i),
        .start_threshold_count_i (start_threshold_count_i),
        .stop_threshold_count_i  (stop_threshold_count_i),
        .max_threshold_count_i   (max_threshold_count_i),
        .input_to_speed_gain_i   (input_to_speed_gain_i),
        .min_speed_code_i        (min_speed_code_i),
        .run_o                   (amap_run),
        .speed_o                 (amap_speed)
    );

    // Square wave on the pulse command input, counted in units of 10 Hz
    mcss_freq_meter #(
        .GATE_CYCLES             (FREQ_GATE_CYCLES),
        .CNT_W                   (16)
    ) u_fmeter (
        .clk_i                   (clk_i),
        .nrst_i                  (nrst_i),
        .pulse_i                 (pulse_command_input_i),
        .count_o                 (freq_count),
        .valid_o                 (freq_valid)
    );

    mcss_cmd_map #(
        .IN_W                    (16)
    ) u_fmap (
        .clk_i                   (clk_i),
        .nrst_i                  (nrst_i),
        .sample_valid_i          (freq_valid),
        .sample_i                (freq_count),
        .dir_i                   (dir_i),
        .start_threshold_count_i (start_threshold_count_i),
        .stop_threshold_count_i  (stop_threshold_count_i),
        .max_threshold_count_i   (max_threshold_count_i),
        .input_to_speed_gain_i   (input_to_speed_gain_i),
        .min_speed_code_i        (min_speed_code_i),
        .run_o                   (fmap_run),
        .speed_o                 (fmap_speed)
    );

    // Duty input arrives already measured in tenths of a percent
    mcss_cmd_map #(
        .IN_W                    (16)
    ) u_dmap (
        .clk_i                   (clk_i),
        .nrst_i                  (nrst_i),
        .sample_valid_i          (duty_valid_i),
        .sample_i                (duty_count_i),
        .dir_i                   (dir_i),
        .start_threshold_count_i (start_threshold_count_i),
        .stop_threshold_count_i  (stop_threshold_count_i),
        .max_threshold_count_i   (max_threshold_count_i),
        .input_to_speed_gain_i   (input_to_speed_gain_i),
        .min_speed_code_i        (min_speed_code_i),
        .run_o                   (dmap_run),
        .speed_o                 (dmap_speed)
    );

    // Source selection; mapped sources are ignored in serial mode
    always @* begin
        run_req = serial_run;
        target  = serial_speed;
        if (cmd_mode_i == `MCSS_MODE_ANALOGUE) begin
            run_req = amap_run;
            target  = amap_speed;
        end else if (cmd_mode_i == `MCSS_MODE_FREQ) begin
            run_req = fmap_run;
            target  = fmap_speed;
        end else if (cmd_mode_i == `MCSS_MODE_DUTY) begin
            run_req = dmap_run;
            target  = dmap_speed;
        end
    end

    // Ramp one step toward the target without overshoot
    always @* begin
        ramp_up   = {ramp[15], ramp} + {1'b0, ramp_step_i};
        ramp_dn   = {ramp[15], ramp} - {1'b0, ramp_step_i};
        next_ramp = ramp;
        if (ramp < target) begin
            next_ramp = (ramp_up > $signed({target[15], target})) ? target : ramp_up[15:0];
        end else if (ramp > target) begin
            next_ramp = (ramp_dn < $signed({target[15], target})) ? target : ramp_dn[15:0];
        end
    end

    // Braking when the rotor runs ahead of the reference or against it
    always @* begin
        is_braking = 1'b0;
        if (!measured_speed_i[15] && (measured_speed_i > ramp)) begin
            is_braking = 1'b1;
        end else if (measured_speed_i[15] && (measured_speed_i < ramp)) begin
            is_braking = 1'b1;
        end
        is_braking = is_braking && (meas_abs > braking_speed_threshold_i);
        motor_cap  = (motoring_torque_limit_i < braking_torque_limit_i) ?
                     braking_torque_limit_i : motoring_torque_limit_i;
    end

    // Start-up supervision
    always @* begin
        next_state    = state;
        next_wait_cnt = wait_cnt;
        case (state)
            `MCSS_ST_IDLE: begin
                next_wait_cnt = 32'h00000000;
                if (run_req) begin
                    next_state = catch_spin_en_i ? `MCSS_ST_SYNC_WAIT : `MCSS_ST_RUN;
                end
            end
            `MCSS_ST_SYNC_WAIT: begin
                next_wait_cnt = wait_cnt + 32'h00000001;
                if (!run_req) begin
                    next_state = `MCSS_ST_IDLE;
                end else if (wait_done) begin
                    next_wait_cnt = 32'h00000000;
                    if (meas_abs >= direct_run_speed_threshold_i) begin
                        next_state = `MCSS_ST_RUN;
                    end else begin
                        next_state = `MCSS_ST_ANGLE_PROBE;
                    end
                end
            end
            `MCSS_ST_ANGLE_PROBE: begin
                next_wait_cnt = wait_cnt + 32'h00000001;
                if (!run_req) begin
                    next_state = `MCSS_ST_IDLE;
                end else if (probe_done) begin
                    next_wait_cnt = 32'h00000000;
                    next_state    = `MCSS_ST_RUN;
                end
            end
            `MCSS_ST_RUN: begin
                if (!run_req) begin
                    next_state = `MCSS_ST_IDLE;
                end
            end
            `MCSS_ST_FAULT: begin
                // A fault present in the clearing cycle keeps the latch
                if (fault_clear_i && !fault_i) begin
                    next_state = `MCSS_ST_IDLE;
                end
            end
            default: begin
                next_state = `MCSS_ST_IDLE;
            end
        endcase
        if (fault_i) begin
            next_state = `MCSS_ST_FAULT;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= `MCSS_ST_IDLE;
            wait_cnt <= 32'h00000000;
            ramp     <= 16'h0000;
        end else begin
            state    <= next_state;
            wait_cnt <= next_wait_cnt;
            if (next_state != `MCSS_ST_RUN) begin
                ramp <= 16'h0000;
            end else if ((state == `MCSS_ST_SYNC_WAIT) && (next_state == `MCSS_ST_RUN)) begin
                ramp <= measured_speed_i;
            end else if (state == `MCSS_ST_RUN) begin
                ramp <= next_ramp;
            end
        end
    end

    // Serial command registers; the switch cycle into serial still selects their old values, then loads present run and speed
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_run   <= 1'b0;
            serial_speed <= 16'h0000;
            mode_d       <= `MCSS_MODE_SERIAL;
        end else begin
            mode_d <= cmd_mode_i;
            if ((cmd_mode_i == `MCSS_MODE_SERIAL) && (mode_d != `MCSS_MODE_SERIAL)) begin
                serial_run   <= running_o;
                serial_speed <= commanded_speed_o;
            end else if (cmd_mode_i == `MCSS_MODE_SERIAL) begin
                if (fault_i || serial_stop_i) begin
                    serial_run <= 1'b0;
                end else if (serial_start_i && (state != `MCSS_ST_FAULT)) begin
                    serial_run <= 1'b1;
                end
                if (serial_speed_valid_i) begin
                    serial_speed <= serial_speed_i;
                end
            end
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_o           <= `MCSS_ST_IDLE;
            inject_enable_o   <= 1'b0;
            speed_reference_o <= 16'h0000;
            commanded_speed_o <= 16'h0000;
            torque_limit_o    <= 16'h0000;
            braking_o         <= 1'b0;
            fault_o           <= 1'b0;
            running_o         <= 1'b0;
        end else begin
            state_o           <= next_state;
            inject_enable_o   <= (next_state == `MCSS_ST_RUN) ||
                                 (next_state == `MCSS_ST_ANGLE_PROBE);
            speed_reference_o <= ramp;
            commanded_speed_o <= target;
            fault_o           <= (next_state == `MCSS_ST_FAULT);
            running_o         <= (next_state == `MCSS_ST_RUN);
            braking_o         <= (state == `MCSS_ST_RUN) && is_braking;
            if (state != `MCSS_ST_RUN) begin
                torque_limit_o <= 16'h0000;
            end else if (is_braking) begin
                torque_limit_o <= braking_torque_limit_i;
            end else begin
                torque_limit_o <= motor_cap;
            end
        end
    end
endmodule

// [test/mcss_pulse_src.sv]
// Purpose: Behavioural frequency-command source driving the pulse command input
// Assumes: Half period counted in clk_i cycles
// Notes:   Output rests low while disabled, as a stopped source would
`timescale 1ns/10ps
module mcss_pulse_src #(
    parameter int HALF = 2
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic en_i,
    output logic      pulse_o
);
    int cnt;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            pulse_o <= 1'b0;
        end else if (!en_i) begin
            cnt <= 0;
            pulse_o <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            pulse_o <= ~pulse_o;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [test/mcss_top_assertions.sv]
// Purpose: Port-level checks of the catch-spin supervisor
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Limits are held steady by the stimulus
`timescale 1ns/10ps
module mcss_top_chk (
    input wire logic              clk_i,
    input wire logic              nrst_i,
    input wire logic              catch_spin_en_i,
    input wire logic [15:0]       direct_run_speed_threshold_i,
    input wire logic [15:0]       braking_speed_threshold_i,
    input wire logic [15:0]       braking_torque_limit_i,
    input wire logic [15:0]       motoring_torque_limit_i,
    input wire logic signed [15:0] measured_speed_i,
    input wire logic              fault_i,
    input wire logic              fault_clear_i,
    input wire logic [2:0]        state_o,
    input wire logic              inject_enable_o,
    input wire logic signed [15:0] speed_reference_o,
    input wire logic [15:0]       torque_limit_o,
    input wire logic              braking_o,
    input wire logic              fault_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire [15:0] mag = measured_speed_i[15] ? 16'(-measured_speed_i) : 16'(measured_speed_i);
    wire [15:0] hi_lim = (motoring_torque_limit_i > braking_torque_limit_i) ?
                         motoring_torque_limit_i : braking_torque_limit_i;
    wait_no_inject_a: assert property (state_o == 3'h1 |-> !inject_enable_o)
        else $error("current injected during sync wait");
    ramp_load_a: assert property ($past(state_o) == 3'h1 && state_o == 3'h3 |=>
        speed_reference_o == $past(measured_speed_i, 2)) else $error("ramp not loaded");
    direct_run_a: assert property (state_o == 3'h0 && !catch_spin_en_i && !fault_i |=>
        state_o inside {3'h0, 3'h3}) else $error("start without catch spin not direct");
    brake_cap_a: assert property (braking_o |-> torque_limit_o == braking_torque_limit_i)
        else $error("braking torque limit wrong");
    brake_cause_a: assert property (braking_o |-> $past(mag) > $past(braking_speed_threshold_i))
        else $error("braking below speed threshold");
    motor_cap_a: assert property (state_o == 3'h3 && $past(state_o) == 3'h3 && !braking_o |->
        torque_limit_o == hi_lim) else $error("motoring torque limit wrong");
    fault_entry_a: assert property (fault_i |=> state_o == 3'h4 && fault_o && !inject_enable_o)
        else $error("fault not entered");
    fault_latch_a: assert property (state_o == 3'h4 && (!fault_clear_i || fault_i) |=>
        state_o == 3'h4) else $error("fault left without clear");
    probe_entry_a: assert property ($past(state_o) == 3'h1 && state_o == 3'h2 |->
        $past(mag) < $past(direct_run_speed_threshold_i)) else $error("probe entered wrongly");
    cover property ($past(state_o) == 3'h1 && state_o == 3'h3);
    cover property (braking_o);
    cover property (state_o == 3'h4);
endmodule
bind mcss_top mcss_top_chk u_chk (.*);

// [test/testbench.sv]
// Purpose: Directed test of start-up supervision and command selection
// Assumes: Short gate and probe counts set by parameter
// Notes:   Inputs change on the falling edge, except the pulse command input, which toggles on the rising edge
`timescale 1ns/10ps
module testbench;
    logic               clk_i = 1'b0;
    logic               nrst_i = 1'b0;
    logic [1:0]         cmd_mode_i = 2'h0;
    logic               catch_spin_en_i = 1'b1;
    logic [31:0]        sync_wait_duration_i = 32'h5;
    logic [15:0]        direct_run_speed_threshold_i = 16'h64;
    logic [15:0]        braking_speed_threshold_i = 16'h3E8;
    logic [15:0]        braking_torque_limit_i = 16'h200;
    logic [15:0]        motoring_torque_limit_i = 16'h400;
    logic [15:0]        ramp_step_i = 16'h0;
    logic signed [15:0] measured_speed_i = 16'sh12C;
    logic signed [15:0] serial_speed_i = 16'sh0;
    logic               fault_i = 0, fault_clear_i = 0, serial_start_i = 0, serial_stop_i = 0;
    logic               serial_speed_valid_i = 0, adc_valid_i = 0, duty_valid_i = 0, dir_i = 0;
    logic               src_en = 0;
    logic               pulse_command_input_i;
    logic [11:0]        adc_speed_i = 12'h0;
    logic [15:0]        duty_count_i = 16'h0;
    logic [15:0]        start_threshold_count_i = 16'h3E8;
    logic [15:0]        stop_threshold_count_i = 16'h1F4;
    logic [15:0]        max_threshold_count_i = 16'hBB8;
    logic [15:0]        input_to_speed_gain_i = 16'h80;
    logic [15:0]        min_speed_code_i = 16'h64;
    logic [2:0]         state_o;
    logic signed [15:0] speed_reference_o, commanded_speed_o;
    logic [15:0]        torque_limit_o;
    logic               inject_enable_o, braking_o, fault_o, running_o;
    int                 n_errors = 0;
    int                 n_checks = 0;
    int                 cycles = 0;
    mcss_top #(.FREQ_GATE_CYCLES(100), .ANGLE_PROBE_CYCLES(8)) u_dut (.*);
    mcss_pulse_src #(.HALF(2)) u_src (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(src_en),
                                      .pulse_o(pulse_command_input_i));
    always #2 clk_i = ~clk_i;
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic wait_st(input logic [2:0] s);
        int i;
        for (i = 0; i < 300 && state_o !== s; i++) cyc(1);
        chk("state_o", {13'h0, s}, {13'h0, state_o});
    endtask
    task automatic adc(input logic [11:0] v);
        adc_speed_i = v;
        pulse(adc_valid_i);
        cyc(2);
    endtask
    initial begin
        cyc(16);
        nrst_i = 1'b1;
        cyc(2);
        pulse(serial_start_i);
        wait_st(3'h1);
        chk("inject", 16'h0, {15'h0, inject_enable_o});
        wait_st(3'h3);
        cyc(2);
        chk("speed_ref", 16'h12C, speed_reference_o);
        serial_speed_i = -16'sd500;
        pulse(serial_speed_valid_i);
        cyc(2);
        chk("commanded", 16'hFE0C, commanded_speed_o);
        adc(12'h5DC);
        chk("commanded", 16'hFE0C, commanded_speed_o);
        pulse(serial_stop_i);
        wait_st(3'h0);
        pulse(fault_i);
        chk("fault", 16'h1, {15'h0, fault_o});
        pulse(serial_start_i);
        cyc(3);
        chk("state_o", 16'h4, {13'h0, state_o});
        pulse(fault_clear_i);
        wait_st(3'h0);
        measured_speed_i = 16'sh0;
        pulse(serial_start_i);
        wait_st(3'h2);
        wait_st(3'h3);
        pulse(serial_stop_i);
        wait_st(3'h0);
        catch_spin_en_i = 1'b0;
        measured_speed_i = 16'sd2000;
        pulse(serial_start_i);
        wait_st(3'h3);
        chk("running", 16'h1, {15'h0, running_o});
        cyc(2);
        chk("braking", 16'h1, {15'h0, braking_o});
        chk("torque", 16'h200, torque_limit_o);
        measured_speed_i = -16'sd500;
        cyc(3);
        chk("braking", 16'h0, {15'h0, braking_o});
        chk("torque", 16'h400, torque_limit_o);
        measured_speed_i = -16'sd2000;
        cyc(3);
        chk("braking", 16'h1, {15'h0, braking_o});
        pulse(serial_stop_i);
        wait_st(3'h0);
        adc(12'h1F3);
        cmd_mode_i = 2'h1;
        ramp_step_i = 16'h100;
        adc(12'h3E8);
        chk("state_o", 16'h0, {13'h0, state_o});
        adc(12'h5DC);
        wait_st(3'h3);
        chk("commanded", 16'h258, commanded_speed_o);
        cyc(4);
        chk("speed_ref", 16'h258, speed_reference_o);
        dir_i = 1'b1;
        adc(12'h2EE);
        chk("commanded", 16'hFF9C, commanded_speed_o);
        chk("speed_ref", 16'h158, speed_reference_o);
        chk("state_o", 16'h3, {13'h0, state_o});
        adc(12'hFA0);
        chk("commanded", 16'hC001, commanded_speed_o);
        dir_i = 1'b0;
        adc(12'h1F4);
        chk("state_o", 16'h3, {13'h0, state_o});
        adc(12'h1F3);
        wait_st(3'h0);
        cmd_mode_i = 2'h3;
        duty_count_i = 16'h5DC;
        pulse(duty_valid_i);
        wait_st(3'h3);
        chk("commanded", 16'h258, commanded_speed_o);
        duty_count_i = 16'h0;
        pulse(duty_valid_i);
        wait_st(3'h0);
        start_threshold_count_i = 16'hA;
        stop_threshold_count_i = 16'h5;
        cmd_mode_i = 2'h2;
        src_en = 1'b1;
        wait_st(3'h3);
        src_en = 1'b0;
        wait_st(3'h0);
        close_out();
    end
endmodule
